// ==== rtl/hazard_cfg.svh ====
`ifndef HAZARD_CFG_SVH
`define HAZARD_CFG_SVH

// ----------------------------------------------------------------------
// resource geometry
// ----------------------------------------------------------------------
`define PRED_COUNT       64
`define PRED_ZERO_IDX    0
`define PRED_LAST_IDX    63
`define OP_W             4
`define MODE_W           2
`define NAT_BIT_W        6
`define RES_ID_W         8
`define USER_NAT_RES_ID  8'h24

// ----------------------------------------------------------------------
// register port map
// ----------------------------------------------------------------------
`define REG_ADDR_W       4
`define REG_CTRL         4'h0
`define REG_STATUS       4'h4
`define REG_COUNT        4'h8
`define CTRL_ENABLE_BIT  0
`define CTRL_RESET       1'b1
`define STAT_LAST_BIT    0
`define STAT_STICKY_BIT  1
`define COUNT_W          16

`endif

// ==== rtl/hazard_pkg.sv ====
package hazard_pkg;

    // ------------------------------------------------------------------
    // decoded instruction class of one slot
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_OTHER          = 4'h0,
        OP_INT_COMPARE    = 4'h1,
        OP_WORD_COMPARE   = 4'h2,
        OP_BIT_TEST       = 4'h3,
        OP_NAT_TEST       = 4'h4,
        OP_FP_COMPARE     = 4'h5,
        OP_FP_RECIP       = 4'h6,
        OP_FP_RSQRT       = 4'h7,
        OP_FP_CLASS       = 4'h8,
        OP_FP_ARITH       = 4'h9,
        OP_SPILL_STORE    = 4'hA,
        OP_MOVE_TO_PRED   = 4'hB,
        OP_MOVE_FROM_PRED = 4'hC,
        OP_BRANCH         = 4'hD,
        OP_LOOP_BRANCH    = 4'hE,
        OP_MOVE_TO_APP    = 4'hF
    } op_t;

    // compare completer family
    typedef enum logic [1:0] {
        CMP_PLAIN = 2'h0,
        CMP_AND   = 2'h1,
        CMP_OR    = 2'h2
    } cmp_mode_t;

endpackage : hazard_pkg

// ==== rtl/slot_effect.sv ====
`timescale 1ns/10ps
`include "hazard_cfg.svh"

module slot_effect
    import hazard_pkg::*;
#(
    parameter int RES_W = `RES_ID_W
)(
    input  wire logic                     valid,
    input  wire logic                     qual,
    input  wire op_t                      op,
    input  wire cmp_mode_t                cmpMode,
    input  wire logic [`PRED_COUNT-1:0]   predWrite,
    input  wire logic [`PRED_COUNT-1:0]   predRead,
    input  wire logic                     resWrite,
    input  wire logic [RES_W-1:0]         resId,
    output logic                          active,
    output logic                          isCompare,
    output cmp_mode_t                     mode,
    output logic [`PRED_COUNT-1:0]        effWrite,
    output logic [`PRED_COUNT-1:0]        effRead,
    output logic                          effRes,
    output logic                          spill,
    output logic                          natMove,
    output logic                          readsLast,
    output logic                          loopWritesLast
);

    logic loop;

    // ------------------------------------------------------------------
    // effective read and write sets of one slot
    // ------------------------------------------------------------------
    always_comb
    begin
        loop = (op == OP_LOOP_BRANCH);
        // loop branches act even when their predicate is false
        active = valid && (qual || loop);
        unique case (op)
            OP_INT_COMPARE, OP_WORD_COMPARE, OP_BIT_TEST, OP_NAT_TEST,
            OP_FP_COMPARE, OP_FP_RECIP, OP_FP_RSQRT, OP_FP_CLASS:
                isCompare = active;
            default:
                isCompare = 1'b0;
        endcase
        mode = cmpMode;
        effWrite = active ? predWrite : '0;   // mask only
        if (active && loop)
            effWrite[`PRED_LAST_IDX] = 1'b1;
        // writes to the zero predicate vanish
        effWrite[`PRED_ZERO_IDX] = 1'b0;
        effRead = !active ? '0 :
                  (op == OP_MOVE_FROM_PRED) ? '1 : predRead;
        // the zero predicate is a constant one, never a hazard
        effRead[`PRED_ZERO_IDX] = 1'b0;
        effRes = active && resWrite;
        spill = active && (op == OP_SPILL_STORE);
        natMove = effRes && (op == OP_MOVE_TO_APP)
                  && (resId == RES_W'(`USER_NAT_RES_ID));
        readsLast = effRead[`PRED_LAST_IDX]
                    && (op == OP_BRANCH || loop);
        loopWritesLast = active && loop;
    end

endmodule : slot_effect

// ==== rtl/pair_hazard.sv ====
`timescale 1ns/10ps
`include "hazard_cfg.svh"

module pair_hazard
    import hazard_pkg::*;
#(
    parameter int RES_W = `RES_ID_W
)(
    input  wire logic                     cmpA,
    input  wire cmp_mode_t                modeA,
    input  wire logic [`PRED_COUNT-1:0]   writeA,
    input  wire logic                     resA,
    input  wire logic [RES_W-1:0]         idA,
    input  wire logic                     spillA,
    input  wire logic [`NAT_BIT_W-1:0]    bitA,
    input  wire logic                     natMoveA,
    input  wire logic                     readsLastA,
    input  wire logic                     cmpB,
    input  wire cmp_mode_t                modeB,
    input  wire logic [`PRED_COUNT-1:0]   writeB,
    input  wire logic                     resB,
    input  wire logic [RES_W-1:0]         idB,
    input  wire logic                     spillB,
    input  wire logic [`NAT_BIT_W-1:0]    bitB,
    input  wire logic                     natMoveB,
    input  wire logic                     loopWritesLastB,
    output logic                          wawPred,
    output logic                          wawRes,
    output logic                          natClash,
    output logic                          warLoop
);

    logic sameFamily;

    // ------------------------------------------------------------------
    // slot A precedes slot B in program order
    // ------------------------------------------------------------------
    always_comb
    begin
        // only matching and/or families may share a target
        sameFamily = cmpA && cmpB && (modeA == modeB)
                     && (modeA == CMP_AND || modeA == CMP_OR);
        wawPred = (|(writeA & writeB)) && !sameFamily;
        // ignored app regs are plain ids here, no exemption
        wawRes = resA && resB && (idA == idB);
        natClash = (spillA && spillB && (bitA == bitB))
                   || (spillA && natMoveB)
                   || (natMoveA && spillB);
        // all other read-before-write orders are legal
        warLoop = readsLastA && loopWritesLastB;
    end

endmodule : pair_hazard

// ==== rtl/group_write_hazard_checker.sv ====
`timescale 1ns/10ps
`include "hazard_cfg.svh"

// Notes on behaviour
// - Compares may share a predicate only if all AND-type or all OR-type.
// - Compare class: int, word, bit and NaT tests, fp compare/approx/class.
// - Any number of writes to the zero predicate is accepted.
// - All other double writes in a group are illegal, predicate moves too.
// - Predicate move writes its mask only; read-all reads every predicate.
// - Fp ops may share a group; status result is OR of all writes.
// - Spill stores clash on the user NaT collection only per bit.
// - Spill store plus app-register move to NaT collection is illegal.
// - Ignored application registers get no exemption from double writes.
// - Branch reads last predicate, later loop branch writes it: illegal.
// - All other write-after-read orders in a group are legal.
// - Slots disabled by a false predicate take part in no check.
// - Zero predicate writes are dropped; its reads always give one.
// - Loop branches read and write regardless of their predicate.
module group_write_hazard_checker
    import hazard_pkg::*;
#(
    parameter int SLOTS  = 6,
    parameter int RES_W  = `RES_ID_W,
    parameter int FLAG_W = 8
)(
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          groupValid,
    input  wire logic [SLOTS-1:0]              slotValid,
    input  wire logic [SLOTS-1:0]              slotQual,
    input  wire logic [SLOTS*`OP_W-1:0]        slotOp,
    input  wire logic [SLOTS*`MODE_W-1:0]      slotCmpMode,
    input  wire logic [SLOTS*`PRED_COUNT-1:0]  slotPredWrite,
    input  wire logic [SLOTS*`PRED_COUNT-1:0]  slotPredRead,
    input  wire logic [SLOTS-1:0]              slotResWrite,
    input  wire logic [SLOTS*RES_W-1:0]        slotResId,
    input  wire logic [SLOTS*`NAT_BIT_W-1:0]   slotNatBit,
    input  wire logic [SLOTS*FLAG_W-1:0]       slotFpFlags,
    input  wire logic [`REG_ADDR_W-1:0]        regAddr,
    input  wire logic [31:0]                   regWrData,
    input  wire logic                          regWrStb,
    input  wire logic                          regRdStb,
    output logic [31:0]                        regRdData,
    output logic                               groupDone,
    output logic                               groupViolation,
    output logic [FLAG_W-1:0]                  fpStatusMerged,
    output logic [FLAG_W-1:0]                  procStatusMerged
);

    // ------------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------------
    if (SLOTS < 2 || SLOTS > 16)
        $error("SLOTS must lie between 2 and 16");
    if (RES_W < `RES_ID_W || FLAG_W < 1 || FLAG_W > 32)
        $error("RES_W or FLAG_W out of range");

    logic                    active     [SLOTS];
    logic                    isCmp      [SLOTS];
    cmp_mode_t               mode       [SLOTS];
    logic [`PRED_COUNT-1:0]  effWrite   [SLOTS];
    logic [`PRED_COUNT-1:0]  effRead    [SLOTS];
    logic                    effRes     [SLOTS];
    logic                    spill      [SLOTS];
    logic                    natMove    [SLOTS];
    logic                    readsLast  [SLOTS];
    logic                    loopWrites [SLOTS];
    logic [SLOTS-1:0]        wawPredMat [SLOTS];
    logic [SLOTS-1:0]        wawResMat  [SLOTS];
    logic [SLOTS-1:0]        natMat     [SLOTS];
    logic [SLOTS-1:0]        warMat     [SLOTS];

    // ------------------------------------------------------------------
    // per-slot effective sets and pairwise comparison
    // ------------------------------------------------------------------
    for (genvar i = 0; i < SLOTS; i++)
    begin : g_slot
        slot_effect #(.RES_W(RES_W)) u_eff (
            .valid          (slotValid[i]),
            .qual           (slotQual[i]),
            .op             (op_t'(slotOp[i*`OP_W +: `OP_W])),
            .cmpMode        (cmp_mode_t'(slotCmpMode[i*`MODE_W +: `MODE_W])),
            .predWrite      (slotPredWrite[i*`PRED_COUNT +: `PRED_COUNT]),
            .predRead       (slotPredRead[i*`PRED_COUNT +: `PRED_COUNT]),
            .resWrite       (slotResWrite[i]),
            .resId          (slotResId[i*RES_W +: RES_W]),
            .active         (active[i]),
            .isCompare      (isCmp[i]),
            .mode           (mode[i]),
            .effWrite       (effWrite[i]),
            .effRead        (effRead[i]),
            .effRes         (effRes[i]),
            .spill          (spill[i]),
            .natMove        (natMove[i]),
            .readsLast      (readsLast[i]),
            .loopWritesLast (loopWrites[i])
        );
        for (genvar j = 0; j < SLOTS; j++)
        begin : g_pair
            if (j > i)
            begin : g_check
                pair_hazard #(.RES_W(RES_W)) u_pair (
                    .cmpA            (isCmp[i]),
                    .modeA           (mode[i]),
                    .writeA          (effWrite[i]),
                    .resA            (effRes[i]),
                    .idA             (slotResId[i*RES_W +: RES_W]),
                    .spillA          (spill[i]),
                    .bitA            (slotNatBit[i*`NAT_BIT_W +: `NAT_BIT_W]),
                    .natMoveA        (natMove[i]),
                    .readsLastA      (readsLast[i]),
                    .cmpB            (isCmp[j]),
                    .modeB           (mode[j]),
                    .writeB          (effWrite[j]),
                    .resB            (effRes[j]),
                    .idB             (slotResId[j*RES_W +: RES_W]),
                    .spillB          (spill[j]),
                    .bitB            (slotNatBit[j*`NAT_BIT_W +: `NAT_BIT_W]),
                    .natMoveB        (natMove[j]),
                    .loopWritesLastB (loopWrites[j]),
                    .wawPred         (wawPredMat[i][j]),
                    .wawRes          (wawResMat[i][j]),
                    .natClash        (natMat[i][j]),
                    .warLoop         (warMat[i][j])
                );
            end
            else
            begin : g_none
                assign wawPredMat[i][j] = 1'b0;
                assign wawResMat[i][j]  = 1'b0;
                assign natMat[i][j]     = 1'b0;
                assign warMat[i][j]     = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // group verdict and merged fp status
    // ------------------------------------------------------------------
    logic              anyHazard;
    logic [FLAG_W-1:0] fpOr;
    logic              checkEnable;
    logic              stickyViolation;
    logic [`COUNT_W-1:0] violationCount;
    logic              next_groupDone;
    logic              next_groupViolation;
    logic [FLAG_W-1:0] next_fpStatusMerged;
    logic [FLAG_W-1:0] next_procStatusMerged;
    logic              next_checkEnable;
    logic              next_stickyViolation;
    logic [`COUNT_W-1:0] next_violationCount;
    logic [31:0]       next_regRdData;

    // fp status writes are never hazards, they simply OR together
    always_comb
    begin
        anyHazard = 1'b0;
        fpOr = '0;
        for (int k = 0; k < SLOTS; k++)
        begin
            anyHazard = anyHazard | (|wawPredMat[k]) | (|wawResMat[k])
                        | (|natMat[k]) | (|warMat[k]);
            if (active[k])
                fpOr = fpOr | slotFpFlags[k*FLAG_W +: FLAG_W];
        end
    end

    // verdict is registered so it stands one cycle after the group
    always_comb
    begin
        next_groupDone = groupValid;
        next_groupViolation = groupViolation;
        next_fpStatusMerged = fpStatusMerged;
        next_procStatusMerged = procStatusMerged;
        if (groupValid)
        begin
            next_groupViolation = anyHazard && checkEnable;
            next_fpStatusMerged = fpOr;
            next_procStatusMerged = fpOr;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            groupDone        <= 1'b0;
            groupViolation   <= 1'b0;
            fpStatusMerged   <= '0;
            procStatusMerged <= '0;
        end
        else
        begin
            groupDone        <= next_groupDone;
            groupViolation   <= next_groupViolation;
            fpStatusMerged   <= next_fpStatusMerged;
            procStatusMerged <= next_procStatusMerged;
        end
    end

    // ------------------------------------------------------------------
    // register port: control, status, violation count
    // ------------------------------------------------------------------
    logic newViolation;

    // a violation in the clearing cycle keeps the sticky bit set
    always_comb
    begin
        newViolation = groupValid && anyHazard && checkEnable;
        next_checkEnable = checkEnable;
        next_stickyViolation = stickyViolation;
        next_violationCount = violationCount;
        next_regRdData = 32'h0000_0000;
        if (regWrStb && regAddr == `REG_CTRL)
            next_checkEnable = regWrData[`CTRL_ENABLE_BIT];
        if (regWrStb && regAddr == `REG_STATUS
            && regWrData[`STAT_STICKY_BIT])
            next_stickyViolation = 1'b0;
        if (newViolation)
        begin
            next_stickyViolation = 1'b1;
            next_violationCount = violationCount + `COUNT_W'(1);
        end
        if (regRdStb)
        begin
            case (regAddr)
                `REG_CTRL:
                    next_regRdData[`CTRL_ENABLE_BIT] = checkEnable;
                `REG_STATUS:
                begin
                    next_regRdData[`STAT_LAST_BIT] = groupViolation;
                    next_regRdData[`STAT_STICKY_BIT] = stickyViolation;
                end
                `REG_COUNT:
                    next_regRdData[`COUNT_W-1:0] = violationCount;
                default:
                    next_regRdData = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            checkEnable     <= `CTRL_RESET;
            stickyViolation <= 1'b0;
            violationCount  <= '0;
            regRdData       <= 32'h0000_0000;
        end
        else
        begin
            checkEnable     <= next_checkEnable;
            stickyViolation <= next_stickyViolation;
            violationCount  <= next_violationCount;
            regRdData       <= next_regRdData;
        end
    end

    // ------------------------------------------------------------------
    // assertions on slots 0 and 1, on the verdict and on the merged fp status
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic [`NAT_BIT_W-1:0] bit0;
    logic [`NAT_BIT_W-1:0] bit1;
    assign bit0 = slotNatBit[0 +: `NAT_BIT_W];
    assign bit1 = slotNatBit[`NAT_BIT_W +: `NAT_BIT_W];

    same_family_a: assert property (
        isCmp[0] && isCmp[1] && mode[0] == mode[1] && mode[0] != CMP_PLAIN
        |-> !wawPredMat[0][1])
        else $error("same-family compares flagged");
    mixed_write_a: assert property (
        |(effWrite[0] & effWrite[1]) && !(isCmp[0] && isCmp[1]
        && mode[0] == mode[1] && mode[0] != CMP_PLAIN)
        |-> wawPredMat[0][1])
        else $error("double predicate write not flagged");
    zero_pred_a: assert property (
        !effWrite[0][`PRED_ZERO_IDX] && !effRead[1][`PRED_ZERO_IDX])
        else $error("zero predicate took part in a check");
    read_all_a: assert property (
        active[0] && op_t'(slotOp[0 +: `OP_W]) == OP_MOVE_FROM_PRED
        |-> &effRead[0][`PRED_COUNT-1:1])
        else $error("read-all predicate move incomplete");
    gated_slot_a: assert property (
        !slotQual[1] && op_t'(slotOp[`OP_W +: `OP_W]) != OP_LOOP_BRANCH
        |-> effWrite[1] == '0 && !effRes[1] && !spill[1])
        else $error("disabled slot still writes");
    loop_pred_a: assert property (
        slotValid[1] && op_t'(slotOp[`OP_W +: `OP_W]) == OP_LOOP_BRANCH
        |-> effWrite[1][`PRED_LAST_IDX])
        else $error("loop branch lost its write");
    spill_bits_a: assert property (
        spill[0] && spill[1] |-> natMat[0][1] == (bit0 == bit1))
        else $error("spill bit clash wrong");
    nat_move_a: assert property (
        spill[0] && natMove[1] |-> natMat[0][1])
        else $error("spill with nat move not flagged");
    war_loop_a: assert property (
        readsLast[0] && loopWrites[1] |-> warMat[0][1] && !warMat[1][0])
        else $error("last predicate war wrong");
    verdict_a: assert property (
        groupValid && checkEnable
        |=> groupDone && groupViolation == $past(anyHazard))
        else $error("verdict not one cycle later");
    fp_merge_a: assert property (
        groupValid |=> fpStatusMerged == $past(fpOr) ##1
        ($past(groupValid) || $stable(fpStatusMerged)))
        else $error("merged fp status wrong");

    ok_group_c:   cover property (groupValid ##1 groupDone && !groupViolation);
    bad_group_c:  cover property (groupValid ##1 groupViolation);
    spill_pair_c: cover property (spill[0] && spill[1] && bit0 != bit1);

endmodule : group_write_hazard_checker

// ==== verification/issue_stage_model.sv ====
`timescale 1ns/10ps
module issue_stage_model
    import hazard_pkg::*;
#(
    parameter int S = 2
)(
    input  wire logic       clk,
    output logic            groupValid,
    output logic [S-1:0]    slotValid,
    output logic [S-1:0]    slotQual,
    output logic [S*4-1:0]  slotOp,
    output logic [S*2-1:0]  slotCmpMode,
    output logic [S*64-1:0] slotPredWrite,
    output logic [S*64-1:0] slotPredRead,
    output logic [S-1:0]    slotResWrite,
    output logic [S*8-1:0]  slotResId,
    output logic [S*6-1:0]  slotNatBit,
    output logic [S*8-1:0]  slotFpFlags
);
    logic [S-1:0]    v, q, e;
    logic [S*4-1:0]  o;
    logic [S*2-1:0]  m;
    logic [S*64-1:0] w, r;
    logic [S*8-1:0]  id, f;
    logic [S*6-1:0]  b;
    // idle lines before the first group
    initial
    begin
        {groupValid, slotValid, slotQual, slotOp, slotCmpMode} = '0;
        {slotPredWrite, slotPredRead, slotResWrite, slotResId} = '0;
        {slotNatBit, slotFpFlags} = '0;
    end
    task automatic clr;
        {v, q, e, o, m, w, r, id, f, b} = '0;
    endtask : clr
    // stage one slot; id zero means no other register written
    task automatic put(input int k, input op_t p, input cmp_mode_t c,
        input logic [63:0] pw, input logic [63:0] pr, input logic [7:0] ri,
        input logic [5:0] nb, input logic [7:0] fl, input logic qu);
        v[k] = 1'h1;
        q[k] = qu;
        o[k*4+:4] = p;
        m[k*2+:2] = c;
        w[k*64+:64] = pw;
        r[k*64+:64] = pr;
        e[k] = ri != 8'h00;
        id[k*8+:8] = ri;
        b[k*6+:6] = nb;
        f[k*8+:8] = fl;
    endtask : put
    // junk on op and predicate-write lines after the strobe, so stale values there never help
    task automatic issue;
        @(posedge clk);
        groupValid <= 1'h1;
        {slotValid, slotQual, slotOp, slotCmpMode} <= {v, q, o, m};
        {slotPredWrite, slotPredRead, slotResWrite} <= {w, r, e};
        {slotResId, slotNatBit, slotFpFlags} <= {id, b, f};
        @(posedge clk);
        groupValid <= 1'h0;
        slotPredWrite <= ~w;
        slotOp <= ~o;
    endtask : issue
endmodule : issue_stage_model

// ==== verification/group_write_hazard_checker_tb.sv ====
`timescale 1ns/10ps
module group_write_hazard_checker_tb
    import hazard_pkg::*;
;
    localparam int S = 2;
    localparam logic [63:0] P5 = 64'h20;
    localparam logic [63:0] P63 = 64'h8000_0000_0000_0000;
    logic            clk, rst, regWrStb, regRdStb, groupDone;
    logic            groupViolation, groupValid, lastV;
    logic [3:0]      regAddr;
    logic [31:0]     regWrData, regRdData;
    logic [7:0]      fpStatusMerged, procStatusMerged;
    logic [S-1:0]    slotValid, slotQual, slotResWrite;
    logic [S*4-1:0]  slotOp;
    logic [S*2-1:0]  slotCmpMode;
    logic [S*64-1:0] slotPredWrite, slotPredRead;
    logic [S*8-1:0]  slotResId, slotFpFlags;
    logic [S*6-1:0]  slotNatBit;
    int              miscompares, compares, nViol;
    group_write_hazard_checker #(.SLOTS(S)) DUT (.*);
    issue_stage_model #(.S(S)) issuer (.*);
    initial
    begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string n, input logic [31:0] x,
        input logic [31:0] g);
        compares++;
        if (g !== x)
        begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    // verdict and merged flags stand one cycle after the strobe
    task automatic grp(input logic ev, input logic [7:0] ef);
        issuer.issue();
        #1;
        chk("done", 32'h1, 32'(groupDone));
        chk("violation", 32'(ev), 32'(groupViolation));
        chk("fp status", 32'(ef), 32'(fpStatusMerged));
        chk("proc status", 32'(ef), 32'(procStatusMerged));
        nViol += 32'(ev);
        lastV = ev;
    endtask : grp
    task automatic pair(input op_t a, input cmp_mode_t ma,
        input logic [63:0] wa, input logic [63:0] ra, input op_t b,
        input cmp_mode_t mb, input logic [63:0] wb, input logic qb,
        input logic ev);
        issuer.clr();
        issuer.put(0, a, ma, wa, ra, '0, '0, '0, 1'h1);
        issuer.put(1, b, mb, wb, '0, '0, '0, '0, qb);
        grp(ev, 8'h00);
    endtask : pair
    task automatic res(input op_t a, input logic [7:0] ia,
        input logic [5:0] na, input op_t b, input logic [7:0] ib,
        input logic [5:0] nb, input logic ev);
        issuer.clr();
        issuer.put(0, a, CMP_PLAIN, '0, '0, ia, na, '0, 1'h1);
        issuer.put(1, b, CMP_PLAIN, '0, '0, ib, nb, '0, 1'h1);
        grp(ev, 8'h00);
    endtask : res
    // one strobe; for a read d is the value expected next cycle
    task automatic regOp(input logic wr, input logic [3:0] a,
        input logic [31:0] d);
        @(posedge clk);
        {regAddr, regWrData, regWrStb, regRdStb} <= {a, d, wr, !wr};
        @(posedge clk);
        {regWrStb, regRdStb} <= 2'h0;
        #1;
        if (!wr)
            chk("register", d, regRdData);
    endtask : regOp
    task automatic tPred;
        for (int k = 0; k <= 8; k++)
        begin
            for (int c = 0; c <= 2; c++)
            begin
                pair(op_t'(k), cmp_mode_t'(c), P5, '0, op_t'(k),
                    cmp_mode_t'(c), P5, 1'h1, k == 0 || c == 0);
            end
        end
        pair(OP_INT_COMPARE, CMP_AND, P5, '0, OP_FP_CLASS, CMP_OR, P5, 1'h1, 1'h1);
        pair(OP_BIT_TEST, CMP_PLAIN, 64'h1, '0, OP_NAT_TEST, CMP_OR, 64'h1, 1'h1, 1'h0);
        pair(OP_MOVE_TO_PRED, CMP_PLAIN, 64'hF0, '0, OP_INT_COMPARE, CMP_AND, 64'h30, 1'h1, 1'h1);
        pair(OP_MOVE_TO_PRED, CMP_PLAIN, 64'hF0, '0, OP_MOVE_TO_PRED, CMP_PLAIN, 64'h0F, 1'h1, 1'h0);
        pair(OP_MOVE_FROM_PRED, CMP_PLAIN, '0, '1, OP_INT_COMPARE, CMP_PLAIN, P5, 1'h1, 1'h0);
        pair(OP_INT_COMPARE, CMP_PLAIN, P5, '0, OP_INT_COMPARE, CMP_PLAIN, P5, 1'h0, 1'h0);
        pair(OP_BRANCH, CMP_PLAIN, '0, P63, OP_LOOP_BRANCH, CMP_PLAIN, '0, 1'h0, 1'h1);
        pair(OP_BRANCH, CMP_PLAIN, '0, P63, OP_INT_COMPARE, CMP_PLAIN, P63, 1'h1, 1'h0);
        $display("predicate groups done");
    endtask : tPred
    task automatic tRes;
        res(OP_OTHER, 8'h11, '0, OP_OTHER, 8'h11, '0, 1'h1);
        res(OP_OTHER, 8'h11, '0, OP_OTHER, 8'h12, '0, 1'h0);
        res(OP_SPILL_STORE, '0, 6'h3, OP_SPILL_STORE, '0, 6'h4, 1'h0);
        res(OP_SPILL_STORE, '0, 6'h3, OP_SPILL_STORE, '0, 6'h3, 1'h1);
        res(OP_SPILL_STORE, '0, 6'h3, OP_MOVE_TO_APP, 8'h24, '0, 1'h1);
        res(OP_MOVE_TO_APP, 8'h24, '0, OP_SPILL_STORE, '0, 6'h5, 1'h1);
        issuer.clr();
        issuer.put(0, OP_FP_ARITH, CMP_PLAIN, '0, '0, '0, '0, 8'h01, 1'h1);
        issuer.put(1, OP_FP_ARITH, CMP_PLAIN, '0, '0, '0, '0, 8'h82, 1'h1);
        grp(1'h0, 8'h83);
        issuer.put(1, OP_FP_ARITH, CMP_PLAIN, '0, '0, '0, '0, 8'h82, 1'h0);
        grp(1'h0, 8'h01);
        $display("register groups done");
    endtask : tRes
    // control, status, count and an unmapped word
    task automatic tRegs;
        regOp(1'h0, 4'h0, 32'h1);
        regOp(1'h0, 4'h8, nViol);
        regOp(1'h0, 4'h4, {30'h0, nViol != 0, lastV});
        regOp(1'h1, 4'h4, 32'h2);
        regOp(1'h0, 4'h4, {31'h0, lastV});
        regOp(1'h0, 4'hC, 32'h0);
        regOp(1'h1, 4'h0, 32'h0);
        res(OP_OTHER, 8'h11, '0, OP_OTHER, 8'h11, '0, 1'h0);
        regOp(1'h1, 4'h0, 32'h1);
        $display("register port done");
    endtask : tRegs
    task automatic wrap_up;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up
    initial
    begin
        {regWrStb, regRdStb, regAddr, regWrData, lastV} = '0;
        {miscompares, compares, nViol} = '0;
        rst = 1'h1;
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        tRegs();
        tPred();
        tRes();
        tRegs();
        wrap_up();
    end
endmodule : group_write_hazard_checker_tb
